/* testbench/octal_driver_spi_command_regs_tb.sv */
`timescale 1ns/1ps
module octal_driver_spi_command_regs_tb;
  import odr_pkg::*;
  logic sys_clk, rst_b, spiClk, csN, sdi, sdo, faultN;
  odr_pins_t pins, p;
  odr_diag_t diag, dd;
  logic [7:0] upperSwitch, lowerSwitch, openWireDetect, a, b, v;
  logic [7:0] r[4];
  logic [1:0] watchdogPeriod;
  logic [15:0] rx;
  int numErrors, samplesChecked, cycles;
  integer seed;
  odr_spi_cmd #(.STRETCH_CYCLES(20), .PARALLEL_CFG(1'b1)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .spiClk(spiClk), .csN(csN), .sdi(sdi), .sdo(sdo), .pins(pins), .diag(diag), .upperSwitch(upperSwitch),
    .lowerSwitch(lowerSwitch), .openWireDetect(openWireDetect), .watchdogPeriod(watchdogPeriod), .faultN(faultN));
  odr_spi_host host (.spiClk(spiClk), .csN(csN), .sdi(sdi), .sdo(sdo));
  // ==========================================
  // Helpers
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      numErrors++;
      finalReport();
    end
  end
  function automatic logic [15:0] fl(odr_diag_t d);
    return {d.thermalTripBits | d.openWire, d.levelAbove7v};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic setin(input odr_pins_t np, input odr_diag_t nd);
    @(posedge sys_clk);
    pins <= np;
    diag <= nd;
    repeat (40) @(posedge sys_clk);
  endtask
  task automatic fr(input logic [15:0] tx, output logic [15:0] got);
    host.xfer(tx, 16, got);
    repeat (10) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] idx, output logic [15:0] got);
    logic [15:0] dummy;
    fr({1'b0, CMD_READ, 5'h00, idx}, dummy);
    fr({1'b0, CMD_STATUS, 8'h00}, got);
  endtask
  task automatic finalReport;
    $display("checks=%0d errors=%0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // Test sequence
  initial begin
    seed = 32'hFB32621A;
    rst_b = 1'b0;
    pins = '0;
    diag = '0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({upperSwitch, lowerSwitch, openWireDetect, watchdogPeriod, faultN}, 27'h0000001);
    $display("test reset done");
    p = '0;
    p.serialSettingSelect = 1'b1;
    p.wideFrameSelect = 1'b1;
    for (int k = 0; k < 4; k++) begin
      dd = '0;
      dd.openWire = $random(seed);
      dd.levelAbove7v = $random(seed);
      setin(p, dd);
      a = (k == 0) ? 8'hFF : 8'($random(seed));
      b = (k == 1) ? 8'hFF : 8'($random(seed));
      fr({a, b}, rx);
      chk(rx, fl(dd));
      chk({upperSwitch, lowerSwitch}, {a, ~a & b});
      chk(faultN, ~|dd.openWire);
    end
    setin(p, '0);
    diag.thermalTripBits <= 8'h81;
    @(posedge sys_clk);
    diag.thermalTripBits <= 8'h00;
    repeat (12) @(posedge sys_clk);
    chk(faultN, 1'b0);
    repeat (30) @(posedge sys_clk);
    chk(faultN, 1'b1);
    p.configSelectPin = 1'b1;
    for (int k = 0; k < 3; k++) begin
      p.openWirePin = k[0];
      setin(p, '0);
      a = $random(seed);
      b = 8'($random(seed)) & ~a;
      v = upperSwitch;
      fr({a, b}, rx);
      chk({upperSwitch, lowerSwitch, openWireDetect}, {v, ~v & b, a | (~(a | b) & {8{p.openWirePin}})});
    end
    $display("test direct done");
    p = '0;
    p.serialSettingSelect = 1'b1;
    p.commandModeSelect = 1'b1;
    p.configSelectPin = 1'b1;
    p.openWirePin = 1'b1;
    dd = '0;
    dd.openWire = $random(seed);
    dd.levelAbove7v = $random(seed);
    setin(p, dd);
    fr({1'b1, CMD_STATUS, 8'h00}, rx);
    for (int k = 0; k < 4; k++) begin
      r[k] = $random(seed);
    end
    v = $random(seed);
    r[3] = {6'h00, v[1] & ~v[0], v[0]};
    for (int k = 0; k < 4; k++) begin
      fr({1'b0, CMD_SET_OUT + 7'(k), r[k]}, rx);
      chk(rx, fl(dd));
    end
    fr({1'b0, CMD_STATUS, 8'hA5}, rx);
    chk({upperSwitch, lowerSwitch, openWireDetect, watchdogPeriod}, {r[0], ~r[0] & r[1], r[2] & ~r[1], r[3][1:0]});
    for (int k = 0; k < 4; k++) begin
      rd(3'(k), rx);
      chk(rx, {8'h00, r[k]});
    end
    fr({1'b0, CMD_STATUS, 8'h00}, rx);
    chk(rx, fl(dd));
    $display("test command done");
    setin(p, '0);
    fr({1'b1, CMD_STATUS, 8'h00}, rx);
    chk(faultN, 1'b1);
    dd = '0;
    v = 8'h01 << ($random(seed) & 7);
    dd.thermalTripBits = v;
    setin(p, dd);
    setin(p, '0);
    chk(faultN, 1'b0);
    host.xfer({1'b1, CMD_STATUS, 8'h00}, 12, rx);
    dd = '0;
    dd.checkErrorFlag = 1'b1;
    setin(p, dd);
    fr({1'b1, CMD_STATUS, 8'h00}, rx);
    setin(p, '0);
    rd(REG_THL, rx);
    chk(rx, {8'h00, v});
    rd(REG_GLL, rx);
    chk(rx[4], 1'b1);
    fr({1'b1, CMD_STATUS, 8'h00}, rx);
    rd(REG_THL, rx);
    chk({rx, faultN}, 17'h00001);
    $display("test latch done");
    p.serialSettingSelect = 1'b0;
    p.drivePins = $random(seed);
    dd = '0;
    dd.aboveSupplyFlags = $random(seed);
    setin(p, dd);
    fr({1'b0, CMD_SET_OUT, ~p.drivePins}, rx);
    fr({1'b0, CMD_SET_MODE, 8'hFF}, rx);
    chk({upperSwitch, lowerSwitch}, {p.drivePins, ~p.drivePins});
    rd(REG_OUT, rx);
    chk(rx, {8'h00, ~p.drivePins});
    rd(REG_OVS, rx);
    chk(rx, {dd.aboveSupplyFlags, 8'h00});
    $display("test parallel done");
    finalReport();
  end
endmodule // octal_driver_spi_command_regs_tb

/* testbench/odr_spi_host.sv */
`timescale 1ns/1ps
module odr_spi_host (
  output logic spiClk, // Serial clock, idle low.
  output logic csN, // Chip select, active low.
  output logic sdi, // Serial data to the device.
  input wire logic sdo // Serial data from the device.
);
  initial begin
    spiClk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
  end
  // ==========================================
  // Frame of n clocks; the line is inverted once released.
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    #1.3 csN = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      sdi = tx[15-i];
      #80 spiClk = 1'b1;
      rx = {rx[14:0], sdo};
      #80 spiClk = 1'b0;
    end
    #80 csN = 1'b1;
    sdi = ~sdi;
    #200;
  endtask
endmodule // odr_spi_host

/* verilog/odr_pkg.sv */
package odr_pkg;
  // ==========================================
  // Frame and command layout
  localparam int FRAME_BITS = 16;
  localparam int CLR_BIT = 15;
  localparam logic [6:0] CMD_SET_OUT = 7'h00;
  localparam logic [6:0] CMD_SET_MODE = 7'h01;
  localparam logic [6:0] CMD_SET_OLEN = 7'h02;
  localparam logic [6:0] CMD_SET_CFG = 7'h03;
  localparam logic [6:0] CMD_READ = 7'h20;
  localparam logic [6:0] CMD_STATUS = 7'h30;
  // ==========================================
  // Register indices and reset values
  localparam logic [2:0] REG_OUT = 3'h0;
  localparam logic [2:0] REG_MODE = 3'h1;
  localparam logic [2:0] REG_OLEN = 3'h2;
  localparam logic [2:0] REG_CFG = 3'h3;
  localparam logic [2:0] REG_OWL = 3'h4;
  localparam logic [2:0] REG_THL = 3'h5;
  localparam logic [2:0] REG_GLL = 3'h6;
  localparam logic [2:0] REG_OVS = 3'h7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int PAIR_UPPER_POS = 3;
  localparam int PAIR_LOWER_POS = 2;
  localparam int WD_LO_POS = 0;
  // Direct-mode pair codes with the config select pin high.
  localparam logic [1:0] PAIR_UPPER_PIN_OW = 2'h0;
  localparam logic [1:0] PAIR_PUSH_PULL = 2'h1;
  localparam logic [1:0] PAIR_UPPER_OW = 2'h2;
  // ==========================================
  // Fault stretching time
  localparam int STRETCH_MS = 200;
  localparam int SYS_CLK_MHZ = 250;
  localparam int STRETCH_CYC = STRETCH_MS * 1000 * SYS_CLK_MHZ;
  // ==========================================
  // Carriers
  typedef struct packed {
    logic serialSettingSelect;
    logic commandModeSelect;
    logic configSelectPin;
    logic wideFrameSelect;
    logic openWirePin;
    logic [7:0] drivePins;
  } odr_pins_t;
  typedef struct packed {
    logic [7:0] openWire;
    logic [7:0] thermalTripBits;
    logic [7:0] aboveSupplyFlags;
    logic [7:0] levelAbove7v;
    logic dieThermalTrip;
    logic watchdogExpiredFlag;
    logic checkErrorFlag;
    logic dcdcLimit;
    logic uvFive;
    logic uvSupply;
    logic supplyWarn;
  } odr_diag_t;
endpackage

/* verilog/odr_spi_cmd.sv */
`timescale 1ns/1ps
module odr_spi_cmd
  import odr_pkg::*;
#(
  parameter int STRETCH_CYCLES = odr_pkg::STRETCH_CYC,
  parameter bit PARALLEL_CFG = 1'b1
) (
  input wire logic sys_clk, // System clock, 250 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic spiClk, // Serial clock from the host.
  input wire logic csN, // Chip select, active low.
  input wire logic sdi, // Serial data in.
  output logic sdo, // Serial data out.
  input wire odr_pkg::odr_pins_t pins, // Mode and drive pins.
  input wire odr_pkg::odr_diag_t diag, // Analog fault and level signals.
  output logic [7:0] upperSwitch, // Upper switch on per channel.
  output logic [7:0] lowerSwitch, // Lower switch on per channel.
  output logic [7:0] openWireDetect, // Open-wire detection active per channel.
  output logic [1:0] watchdogPeriod, // Active watchdog period field.
  output logic faultN // Global fault, active low.
);
  import odr_pkg::*;

  // ==========================================
  // Link domain: shift in, count, shift out
  logic [FRAME_BITS-1:0] rxShift_q;
  logic [7:0] bitCnt_q;
  logic started_q;
  logic frameTog_q;
  logic sdoShift_q;
  logic sdoUsed_q;
  logic [FRAME_BITS-1:0] txWord_q;

  always_ff @(posedge spiClk or posedge csN) begin
    if (csN) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  always_ff @(posedge spiClk) begin
    rxShift_q <= {rxShift_q[FRAME_BITS-2:0], sdi};
    bitCnt_q <= started_q ? bitCnt_q + 8'h01 : 8'h01;
    frameTog_q <= started_q ? frameTog_q : ~frameTog_q;
  end

  // Past the own word the received bits pass on for the next chained device.
  always_ff @(negedge spiClk) begin
    if (bitCnt_q < 8'(FRAME_BITS)) begin
      sdoShift_q <= txWord_q[4'(FRAME_BITS - 1) - bitCnt_q[3:0]];
    end else begin
      sdoShift_q <= rxShift_q[FRAME_BITS-1];
    end
  end

  always_ff @(negedge spiClk or posedge csN) begin
    if (csN) begin
      sdoUsed_q <= 1'b0;
    end else begin
      sdoUsed_q <= 1'b1;
    end
  end

  // The first bit must stand before any clock edge, so it comes from the word itself.
  assign sdo = sdoUsed_q ? sdoShift_q : txWord_q[FRAME_BITS-1];

  // ==========================================
  // Synchronisers
  logic csS1_q, csS2_q, csPrev_q;
  logic togS1_q, togS2_q, togSeen_q;
  odr_pins_t pinS1_q, pinS_q;
  odr_diag_t diagS1_q, diagS_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      csS1_q <= 1'b1;
      csS2_q <= 1'b1;
      csPrev_q <= 1'b1;
      togS1_q <= 1'b0;
      togS2_q <= 1'b0;
      pinS1_q <= '0;
      pinS_q <= '0;
      diagS1_q <= '0;
      diagS_q <= '0;
    end else begin
      csS1_q <= csN;
      csS2_q <= csS1_q;
      csPrev_q <= csS2_q;
      togS1_q <= frameTog_q;
      togS2_q <= togS1_q;
      pinS1_q <= pins;
      pinS_q <= pinS1_q;
      diagS1_q <= diag;
      diagS_q <= diagS1_q;
    end
  end

  // Link words are read only while chip select holds the link clock still.
  logic frameEnd, frameStart, clocked, cntBad, frameGood;
  logic cmdMode, serialSet, latchedPin;
  logic zBit, clearNow;
  logic [6:0] rxCmd;
  logic [7:0] rxData;

  assign frameEnd = csS2_q & ~csPrev_q;
  assign frameStart = ~csS2_q & csPrev_q;
  assign clocked = togS2_q != togSeen_q;
  assign cntBad = frameEnd & clocked & (bitCnt_q[2:0] != 3'h0);
  assign frameGood = frameEnd & clocked & ~cntBad & ~diagS_q.checkErrorFlag & (bitCnt_q >= 8'(FRAME_BITS));
  assign cmdMode = pinS_q.commandModeSelect;
  assign serialSet = pinS_q.serialSettingSelect;
  assign latchedPin = serialSet & cmdMode;
  assign zBit = rxShift_q[CLR_BIT];
  assign rxCmd = rxShift_q[14:8];
  assign rxData = rxShift_q[7:0];
  assign clearNow = frameGood & cmdMode & zBit;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      togSeen_q <= 1'b0;
    end else if (frameEnd) begin
      togSeen_q <= togS2_q;
    end
  end

  // ==========================================
  // Fault stretching and latching
  logic [17:0] rawFault, strFault;
  logic [7:0] owRt, thRt, rtFault, rtGlobal;
  logic clkErrRt, dieRt, rtAny;
  logic [7:0] owPrev_q, thPrev_q, glPrev_q;
  logic [7:0] owLatch_q, thLatch_q, glLatch_q;
  logic anyPrev_q, faultLatch_q;

  assign rawFault = {cntBad, diagS_q.dieThermalTrip, diagS_q.thermalTripBits, diagS_q.openWire};

  odr_stretch #(
    .WIDTH(18),
    .CYCLES(STRETCH_CYCLES)
  ) u_stretch (
    .sysClk(sys_clk),
    .rstN(rst_b),
    .rawIn(rawFault),
    .stretchedOut(strFault)
  );

  assign owRt = strFault[7:0];
  assign thRt = strFault[15:8];
  assign dieRt = strFault[16];
  assign clkErrRt = strFault[17];
  assign rtFault = owRt | thRt;
  assign rtGlobal = {diagS_q.watchdogExpiredFlag, diagS_q.checkErrorFlag, diagS_q.dcdcLimit, clkErrRt,
                     dieRt, diagS_q.uvFive, diagS_q.uvSupply, diagS_q.supplyWarn};
  assign rtAny = (|rtFault) | dieRt | clkErrRt;

  // A rise in the clearing cycle wins over the clear.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      owPrev_q <= 8'h00;
      thPrev_q <= 8'h00;
      glPrev_q <= 8'h00;
      owLatch_q <= 8'h00;
      thLatch_q <= 8'h00;
      glLatch_q <= 8'h00;
    end else begin
      owPrev_q <= owRt;
      thPrev_q <= thRt;
      glPrev_q <= rtGlobal;
      owLatch_q <= (clearNow ? 8'h00 : owLatch_q) | (owRt & ~owPrev_q);
      thLatch_q <= (clearNow ? 8'h00 : thLatch_q) | (thRt & ~thPrev_q);
      glLatch_q <= (clearNow ? 8'h00 : glLatch_q) | (rtGlobal & ~glPrev_q);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      anyPrev_q <= 1'b0;
      faultLatch_q <= 1'b0;
      faultN <= 1'b1;
    end else begin
      anyPrev_q <= rtAny;
      faultLatch_q <= ((clearNow & latchedPin) ? 1'b0 : faultLatch_q) | (rtAny & ~anyPrev_q);
      faultN <= latchedPin ? ~faultLatch_q : ~rtAny;
    end
  end

  // ==========================================
  // Registers written by frames
  logic [7:0] outSet_q, styleReg_q, olEn_q, wdj_q, olFollow_q;
  logic directWr, cmdWr;

  assign directWr = frameGood & ~cmdMode & serialSet & pinS_q.wideFrameSelect;
  assign cmdWr = frameGood & cmdMode & (serialSet | PARALLEL_CFG);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      outSet_q <= REG_RESET;
      styleReg_q <= REG_RESET;
      olEn_q <= REG_RESET;
      wdj_q <= REG_RESET;
      olFollow_q <= 8'h00;
    end else if (directWr) begin
      if (!pinS_q.configSelectPin) begin
        outSet_q <= rxShift_q[15:8];
        styleReg_q <= rxShift_q[7:0];
      end else begin
        for (int i = 0; i < 8; i++) begin
          case ({rxShift_q[8+i], rxShift_q[i]})
            PAIR_UPPER_PIN_OW: begin
              styleReg_q[i] <= 1'b0;
              olFollow_q[i] <= 1'b1;
            end
            PAIR_PUSH_PULL: begin
              styleReg_q[i] <= 1'b1;
              olFollow_q[i] <= 1'b0;
            end
            PAIR_UPPER_OW: begin
              styleReg_q[i] <= 1'b0;
              olEn_q[i] <= 1'b1;
              olFollow_q[i] <= 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
    end else if (frameGood & cmdMode) begin
      if (rxCmd == CMD_SET_OUT) begin
        outSet_q <= rxData;
      end
      if (cmdWr) begin
        case (rxCmd)
          CMD_SET_MODE: styleReg_q <= rxData;
          CMD_SET_OLEN: begin
            olEn_q <= rxData;
            olFollow_q <= 8'h00;
          end
          CMD_SET_CFG: wdj_q <= {4'h0, rxData[3:0]};
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================
  // Active configuration and output drive
  logic [7:0] styleAct_q, olAct_q, wdjAct_q, olFollowAct_q;
  logic [7:0] drive, joinMask, styleEff, olEff;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      styleAct_q <= REG_RESET;
      olAct_q <= REG_RESET;
      wdjAct_q <= REG_RESET;
      olFollowAct_q <= 8'h00;
    end else if (serialSet | PARALLEL_CFG) begin
      styleAct_q <= styleReg_q;
      olAct_q <= olEn_q;
      wdjAct_q <= wdj_q;
      olFollowAct_q <= olFollow_q;
    end
  end

  assign drive = serialSet ? outSet_q : pinS_q.drivePins;
  assign joinMask = {{4{wdjAct_q[PAIR_UPPER_POS]}}, {4{wdjAct_q[PAIR_LOWER_POS]}}};
  assign styleEff = styleAct_q & ~joinMask;
  assign olEff = (olFollowAct_q & ~{8{cmdMode}}) != 8'h00 ?
                 ((olFollowAct_q & {8{pinS_q.openWirePin}}) | (olAct_q & ~olFollowAct_q)) : olAct_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      upperSwitch <= 8'h00;
      lowerSwitch <= 8'h00;
      openWireDetect <= 8'h00;
      watchdogPeriod <= 2'h0;
    end else begin
      upperSwitch <= drive;
      lowerSwitch <= ~drive & styleEff;
      openWireDetect <= olEff & ~styleEff;
      watchdogPeriod <= wdjAct_q[WD_LO_POS+1:WD_LO_POS];
    end
  end

  // ==========================================
  // Answer word, built at the start of each frame
  logic pendRead_q;
  logic [2:0] pendIdx_q;

  function automatic logic [7:0] regValue(input logic [2:0] idx);
    case (idx)
      REG_OUT: regValue = outSet_q;
      REG_MODE: regValue = styleReg_q;
      REG_OLEN: regValue = olEn_q;
      REG_CFG: regValue = wdj_q;
      REG_OWL: regValue = owLatch_q;
      REG_THL: regValue = thLatch_q;
      REG_GLL: regValue = glLatch_q;
      default: regValue = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] rtValue(input logic [2:0] idx);
    case (idx)
      REG_OWL: rtValue = owRt;
      REG_THL: rtValue = thRt;
      REG_GLL: rtValue = rtGlobal;
      REG_OVS: rtValue = diagS_q.aboveSupplyFlags;
      default: rtValue = 8'h00;
    endcase
  endfunction

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pendRead_q <= 1'b0;
      pendIdx_q <= 3'h0;
    end else if (frameEnd & clocked) begin
      pendRead_q <= frameGood & cmdMode & (rxCmd == CMD_READ);
      pendIdx_q <= rxData[2:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txWord_q <= '0;
    end else if (frameStart) begin
      if (cmdMode & pendRead_q) begin
        txWord_q <= {rtValue(pendIdx_q), regValue(pendIdx_q)};
      end else begin
        txWord_q <= {rtFault, diagS_q.levelAbove7v};
      end
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_clear_on_z: assert property (clearNow && !(|(owRt & ~owPrev_q)) |=> owLatch_q == 8'h00)
    else $error("latch not cleared by clear bit");
  a_bad_no_clear: assert property (frameEnd && (cntBad || diagS_q.checkErrorFlag) |-> !clearNow)
    else $error("bad frame cleared latches");
  a_latch_set: assert property ($rose(thRt[0]) |=> thLatch_q[0])
    else $error("thermal latch missed a rise");
  a_parallel_pins: assert property (!serialSet && $stable(serialSet) |=> upperSwitch == $past(pinS_q.drivePins))
    else $error("parallel outputs not following pins");
  a_fault_realtime: assert property (!latchedPin && $stable(latchedPin) |=> faultN == !$past(rtAny))
    else $error("fault pin not real-time");
  a_no_crossbar: assert property ((upperSwitch & lowerSwitch) == 8'h00)
    else $error("both switches on");
  a_read_seven: assert property (frameStart && cmdMode && pendRead_q && pendIdx_q == REG_OVS
    |=> txWord_q[7:0] == 8'h00 && txWord_q[15:8] == $past(diagS_q.aboveSupplyFlags))
    else $error("register seven read wrong");
  a_status_word: assert property (frameStart && !(cmdMode && pendRead_q) |=> txWord_q == {$past(rtFault), $past(diagS_q.levelAbove7v)})
    else $error("status word wrong");
  a_out_frame_end: assert property (serialSet && $stable(serialSet) && !$past(frameEnd) |-> $stable(outSet_q))
    else $error("output setting moved mid frame");
endmodule // odr_spi_cmd

/* verilog/odr_stretch.sv */
`timescale 1ns/1ps
module odr_stretch #(
  parameter int WIDTH = 18,
  parameter int CYCLES = 16
) (
  input wire logic sysClk, // System clock.
  input wire logic rstN, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] rawIn, // Real-time fault levels.
  output logic [WIDTH-1:0] stretchedOut // Faults held high for at least CYCLES.
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  logic [CW-1:0] holdCnt_q [WIDTH];

  // ==========================================
  // Per-bit hold counters
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge sysClk or negedge rstN) begin
      if (!rstN) begin
        holdCnt_q[i] <= '0;
        stretchedOut[i] <= 1'b0;
      end else begin
        if (rawIn[i]) begin
          holdCnt_q[i] <= LOAD;
        end else if (holdCnt_q[i] != '0) begin
          holdCnt_q[i] <= holdCnt_q[i] - 1'b1;
        end
        stretchedOut[i] <= rawIn[i] | (holdCnt_q[i] != '0);
      end
    end
  end

  a_stretch_min: assert property (@(posedge sysClk) disable iff (!rstN)
    $rose(stretchedOut[0]) |=> stretchedOut[0] [*8]) else $error("stretched fault dropped early");
endmodule // odr_stretch
